/* File: core/flsu_map.svh */
`ifndef FLSU_MAP_SVH
`define FLSU_MAP_SVH
// register byte offsets on the AHB-Lite slave
`define FLSU_CTRL_OFS 12'h000
`define FLSU_STAT_OFS 12'h004
`define FLSU_ALAT_OFS 12'h008
`define FLSU_AW 12
// control register bit positions
`define FLSU_CB_FMISS 0
`define FLSU_CB_ED 1
`define FLSU_CB_BE 2
`define FLSU_CB_DLO 3
`define FLSU_CB_DHI 4
`define FLSU_CTRL_W 5
`define FLSU_CTRL_RST 5'h00
// access sizes in bytes
`define FLSU_SZ_S 5'h04
`define FLSU_SZ_D 5'h08
`define FLSU_SZ_E 5'h0a
`define FLSU_SZ_FILL 5'h10
`define FLSU_SZ_PAIR_S 5'h08
`define FLSU_SZ_PAIR_D 5'h10
// exponent constants of the register format
`define FLSU_EXP_INT 17'h1_003e
`define FLSU_EXP_MAX 17'h1_ffff
`define FLSU_BIAS_REG 17'h0_ffff
`define FLSU_BIAS_S 17'h0_007f
`define FLSU_BIAS_D 17'h0_03ff
`define FLSU_BIAS_E 17'h0_3fff
// result constants; the token encoding is arbitrary
`define FLSU_INT_ZERO {1'b0, `FLSU_EXP_INT, 64'h0000_0000_0000_0000}
`define FLSU_TOKEN {1'b0, `FLSU_EXP_MAX, 64'h0000_0000_0000_0001}
// float register partitions
`define FLSU_FR_FIRST_MOD 7'h02
`define FLSU_FR_LOW_LAST 7'h1f
// advanced-load table
`define FLSU_ALAT_N 4
`define FLSU_ALAT_IW 2
`endif

/* File: core/flsu_pkg.sv */
package flsu_pkg;
   typedef enum logic [2:0] {LT_NONE, LT_S, LT_A, LT_SA, LT_CNC, LT_CCLR} flsu_ldtype_t;
   typedef enum logic [1:0] {FMT_S, FMT_D, FMT_E} flsu_fmt_t;
   typedef enum logic [1:0] {FORM_FP, FORM_INT, FORM_FILL} flsu_form_t;
   typedef enum logic [1:0] {UPD_NONE, UPD_IMM, UPD_REG} flsu_upd_t;
   typedef enum logic [2:0] {FLT_NONE, FLT_ILLEGAL, FLT_DISABLED, FLT_NAT, FLT_MEM} flsu_fault_t;
   typedef enum logic [1:0] {ST_IDLE, ST_EVAL, ST_MEM, ST_FIN} flsu_state_t;
   typedef struct packed {
      logic qp;
      flsu_ldtype_t ldtype;
      flsu_fmt_t fmt;
      flsu_form_t form;
      logic pair;
      flsu_upd_t upd;
      logic [6:0] f1;
      logic [6:0] f2;
      logic [6:0] r3;
      logic [63:0] base;
      logic base_nat;
      logic [63:0] r2_val;
      logic r2_nat;
      logic [8:0] short_signed_offset;
      logic [1:0] hint;
   } flsu_req_t;
   typedef struct packed {logic sign; logic [16:0] exp; logic [63:0] sig;} flsu_freg_t;
   typedef struct packed {logic valid; logic [6:0] idx; flsu_freg_t val;} flsu_frwr_t;
   typedef struct packed {
      logic valid;
      logic [63:0] vaddr;
      logic [4:0] size;
      logic [1:0] hint;
      logic spec;
      logic adv;
      logic big_endian;
   } flsu_mreq_t;
   typedef struct packed {
      logic ack;
      logic [127:0] data;
      logic [63:0] paddr;
      logic spec_page;
      logic defer;
      logic fault;
   } flsu_mrsp_t;
   typedef struct packed {logic valid; logic [6:0] freg; logic [63:0] paddr; logic [4:0] size;} flsu_alat_t;
   typedef struct packed {logic sign; logic [7:0] exp; logic [22:0] frac;} flsu_sgl_t;
   typedef struct packed {logic sign; logic [10:0] exp; logic [51:0] frac;} flsu_dbl_t;
   typedef struct packed {logic sign; logic [14:0] exp; logic [63:0] sig;} flsu_ext_t;
endpackage

/* File: core/flsu_unit.sv */
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "flsu_map.svh"
// Operation
// - non-pair immediate update adds sign-extended 9-bit offset to base after access
// - register update adds second register; deferred bits ORed, no fault
// - size: fill 16, integer 8, else single 4, double 8, extended 10
// - speculative deferral writes the deferred token into the target
// - advanced non-speculative deferral writes zero, integer zero has 0x1003E exponent
// - zero only for advanced non-speculative defer, token for speculative, else convert
// - completed check-no-clear or advanced load allocates entry on speculative page
// - advanced and clear-check accesses invalidate the target's table entry
// - check-no-clear hit: no access, target unchanged
// - check loads do base update on hit and on miss
// - lookup may be forced to miss
// - check-no-clear miss loads and allocates unless page non-speculative
// - clear-check hit removes entry, no access; miss acts as normal load
// - non-speculative types fault on deferred address bit; speculative types defer
// - speculative defers on address bit or defer flag, skipping the read
// - disabled target faults; base register validated in update forms
// - update forms with clear deferred bit hint a prefetch at new base
// - no-update forms leave base alone and give no prefetch hint
// - low and high modified flags follow written register partitions
// - pair reads 8 or 16 bytes; immediate update advances base by that amount
// - pair splits halves, lower address to first target
// - pair treats halves as two floats, or integer data in integer form
// - integer form puts raw bytes in significand, exponent 0x1003E, positive
// - pair targets must be one odd and one even physical register
module flsu_unit import flsu_pkg::*; (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic req_valid,
   input wire flsu_req_t req,
   output logic req_ready,
   output flsu_mreq_t mreq,
   input wire flsu_mrsp_t mrsp,
   output flsu_frwr_t fr_wr0,
   output flsu_frwr_t fr_wr1,
   output logic gr_wr_valid,
   output logic [6:0] gr_wr_idx,
   output logic [63:0] gr_wr_val,
   output logic gr_wr_nat,
   output logic pf_valid,
   output logic [63:0] pf_addr,
   output logic [1:0] pf_hint,
   output logic fault_valid,
   output flsu_fault_t fault_code,
   output logic done
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   // partition of a float register: bit 1 high part, bit 0 low part
   function automatic logic [1:0] fr_part(input logic [6:0] f);
      fr_part = {f > `FLSU_FR_LOW_LAST, (f >= `FLSU_FR_FIRST_MOD) && (f <= `FLSU_FR_LOW_LAST)};
   endfunction

   function automatic logic [`FLSU_ALAT_IW-1:0] first_idx(input logic [`FLSU_ALAT_N-1:0] v);
      first_idx = '0;
      for (int i = `FLSU_ALAT_N - 1; i >= 0; i--) begin
         if (v[i]) begin
            first_idx = i[`FLSU_ALAT_IW-1:0];
         end
      end
   endfunction

   // zero and all-ones exponents keep their meaning, others move to register bias
   function automatic logic [16:0] rebias(input logic [16:0] e, input logic [16:0] bias);
      if (e == '0) begin
         rebias = '0;
      end else if (e == {bias[15:0], 1'b1}) begin
         rebias = `FLSU_EXP_MAX;
      end else begin
         rebias = e - bias + `FLSU_BIAS_REG;
      end
   endfunction

   // memory format to register format; denormals keep a zero integer bit only
   function automatic flsu_freg_t fp_conv(input logic [79:0] v, input flsu_fmt_t fmt,
                                          input logic is_int);
      flsu_sgl_t s;
      flsu_dbl_t d;
      flsu_ext_t x;
      flsu_freg_t r;
      s = v[31:0];
      d = v[63:0];
      x = v;
      r = '0;
      if (is_int) begin
         r.exp = `FLSU_EXP_INT;
         r.sig = v[63:0];
      end else begin
         unique case (fmt)
            FMT_S: begin
               r.sign = s.sign;
               r.exp = rebias(17'(s.exp), `FLSU_BIAS_S);
               r.sig = {s.exp != '0, s.frac, {40{1'b0}}};
            end
            FMT_D: begin
               r.sign = d.sign;
               r.exp = rebias(17'(d.exp), `FLSU_BIAS_D);
               r.sig = {d.exp != '0, d.frac, {11{1'b0}}};
            end
            default: begin
               r.sign = x.sign;
               r.exp = rebias(17'(x.exp), `FLSU_BIAS_E);
               r.sig = x.sig;
            end
         endcase
      end
      fp_conv = r;
   endfunction

   flsu_state_t st_reg, st_next;
   flsu_req_t q_reg;
   flsu_mrsp_t rsp_reg;
   flsu_alat_t alat_reg [`FLSU_ALAT_N];
   logic [`FLSU_ALAT_IW-1:0] rr_reg;
   logic defer_reg, hit_reg, mreq_v_reg;
   logic [`FLSU_CTRL_W-1:0] ctrl_reg;
   logic [1:0] mf_reg;
   flsu_fault_t last_fault_reg;
   logic a_valid_reg, a_wr_reg;
   logic [`FLSU_AW-1:0] a_addr_reg;

   // instruction decode
   wire spec = (q_reg.ldtype == LT_S) || (q_reg.ldtype == LT_SA);
   wire adv = (q_reg.ldtype == LT_A) || (q_reg.ldtype == LT_SA);
   wire cclr = q_reg.ldtype == LT_CCLR;
   wire cnc = q_reg.ldtype == LT_CNC;
   wire chk = cclr || cnc;
   wire upd_on = q_reg.upd != UPD_NONE;
   wire is_int = q_reg.form == FORM_INT;
   wire pair_s = q_reg.pair && (q_reg.fmt == FMT_S) && !is_int;
   wire big_endian_control = ctrl_reg[`FLSU_CB_BE];
   wire exception_defer_flag = ctrl_reg[`FLSU_CB_ED];
   wire fin = st_reg == ST_FIN;
   wire ev = st_reg == ST_EVAL;
   wire [1:0] dis_mask = {ctrl_reg[`FLSU_CB_DHI], ctrl_reg[`FLSU_CB_DLO]};

   // access size selection; pair sizes double as base step
   wire [4:0] sz_elem = (q_reg.fmt == FMT_S) ? `FLSU_SZ_S :
                        (q_reg.fmt == FMT_D) ? `FLSU_SZ_D : `FLSU_SZ_E;
   wire [4:0] size_sel = q_reg.pair ? (pair_s ? `FLSU_SZ_PAIR_S : `FLSU_SZ_PAIR_D) :
                         (q_reg.form == FORM_FILL) ? `FLSU_SZ_FILL :
                         is_int ? `FLSU_SZ_D : sz_elem;

   // checks made before any access, in priority order
   wire illegal = (upd_on && (q_reg.r3 == '0)) ||
                  (q_reg.pair && (q_reg.f1[0] == q_reg.f2[0]));
   wire [1:0] tgt_part = fr_part(q_reg.f1) | (q_reg.pair ? fr_part(q_reg.f2) : 2'b00);
   wire dis_hit = |(tgt_part & dis_mask);
   wire nat_flt = !spec && q_reg.base_nat;
   wire eval_defer = spec && (q_reg.base_nat || exception_defer_flag);
   wire flsu_fault_t eval_flt = !q_reg.qp ? FLT_NONE : illegal ? FLT_ILLEGAL :
                                dis_hit ? FLT_DISABLED : nat_flt ? FLT_NAT : FLT_NONE;

   // table lookup by first target; a forced miss hides any match
   logic [`FLSU_ALAT_N-1:0] hit_vec, free_vec;
   genvar gi;
   generate
      for (gi = 0; gi < `FLSU_ALAT_N; gi++) begin : g_cmp
         assign hit_vec[gi] = alat_reg[gi].valid && (alat_reg[gi].freg == q_reg.f1);
         assign free_vec[gi] = !alat_reg[gi].valid;
      end
   endgenerate
   wire hit = chk && (|hit_vec) && !ctrl_reg[`FLSU_CB_FMISS];

   // translation deferral only exists for speculative or advanced types
   wire mem_def = mrsp.defer && (spec || adv);
   wire mem_flt = (st_reg == ST_MEM) && mrsp.ack && (mrsp.fault || (mrsp.defer && !mem_def));
   wire flsu_fault_t flt_next = ev ? eval_flt : (mem_flt ? FLT_MEM : FLT_NONE);

   // state sequencing
   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         ST_IDLE: if (req_valid) st_next = ST_EVAL;
         ST_EVAL: begin
            if (!q_reg.qp || (eval_flt != FLT_NONE)) st_next = ST_IDLE;
            else if (hit || eval_defer) st_next = ST_FIN;
            else st_next = ST_MEM;
         end
         ST_MEM: if (mrsp.ack) st_next = mem_flt ? ST_IDLE : ST_FIN;
         ST_FIN: st_next = ST_IDLE;
      endcase
   end

   // capture of instruction, lookup result and memory answer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= ST_IDLE;
         q_reg <= '0;
         rsp_reg <= '0;
         defer_reg <= 1'b0;
         hit_reg <= 1'b0;
         mreq_v_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         if (st_reg == ST_IDLE && req_valid) q_reg <= req;
         if (ev) defer_reg <= eval_defer;
         if (ev) hit_reg <= hit;
         if (st_reg == ST_MEM && mrsp.ack) rsp_reg <= mrsp;
         if (st_reg == ST_MEM && mrsp.ack) defer_reg <= defer_reg | mem_def;
         mreq_v_reg <= (ev && st_next == ST_MEM) || (mreq_v_reg && !mrsp.ack);
      end
   end

   // the access always uses the base before any update
   assign mreq = '{valid: mreq_v_reg, vaddr: q_reg.base, size: size_sel, hint: q_reg.hint,
                   spec: spec, adv: adv, big_endian: big_endian_control};
   assign req_ready = st_reg == ST_IDLE;

   // result selection; memory returns the value already assembled in its byte order
   wire access = !hit_reg;
   wire [63:0] half_lo = pair_s ? 64'(rsp_reg.data[31:0]) : rsp_reg.data[63:0];
   wire [63:0] half_hi = pair_s ? 64'(rsp_reg.data[63:32]) : rsp_reg.data[127:64];
   wire flsu_fmt_t pfmt = pair_s ? FMT_S : FMT_D;
   wire [63:0] first_half = big_endian_control ? half_hi : half_lo;
   wire [63:0] second_half = big_endian_control ? half_lo : half_hi;
   wire flsu_freg_t ld0 = q_reg.pair ? fp_conv(80'(first_half), pfmt, is_int) :
                          (q_reg.form == FORM_FILL) ? flsu_freg_t'(rsp_reg.data[81:0]) :
                          fp_conv(rsp_reg.data[79:0], q_reg.fmt, is_int);
   wire flsu_freg_t ld1 = fp_conv(80'(second_half), pfmt, is_int);
   wire flsu_freg_t zero_val = is_int ? flsu_freg_t'(`FLSU_INT_ZERO) : '0;
   wire flsu_freg_t dval = spec ? flsu_freg_t'(`FLSU_TOKEN) : zero_val;
   wire flsu_frwr_t fr0_next = '{valid: fin && access, idx: q_reg.f1,
                                 val: defer_reg ? dval : ld0};
   wire flsu_frwr_t fr1_next = '{valid: fin && access && q_reg.pair, idx: q_reg.f2,
                                 val: defer_reg ? dval : ld1};
   wire [1:0] mf_set = (fin && access) ? tgt_part : 2'b00;

   // base update happens on hit and miss alike; pair with immediate update steps by its size
   wire [63:0] imm_ext = 64'($signed(q_reg.short_signed_offset));
   wire [63:0] step = (q_reg.upd == UPD_REG) ? q_reg.r2_val :
                      q_reg.pair ? 64'(size_sel) : imm_ext;
   wire [63:0] base_new = q_reg.base + step;
   wire nat_new = q_reg.base_nat || ((q_reg.upd == UPD_REG) && q_reg.r2_nat);

   // table maintenance at the end of the instruction
   wire inval = fin && ((hit_reg && cclr) || (access && (cclr || adv)));
   wire alloc = fin && access && !defer_reg && (cnc || adv) && rsp_reg.spec_page;
   wire [`FLSU_ALAT_IW-1:0] slot = (|hit_vec) ? first_idx(hit_vec) :
                                   (|free_vec) ? first_idx(free_vec) : rr_reg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < `FLSU_ALAT_N; i++) alat_reg[i] <= '0;
         rr_reg <= '0;
      end else begin
         for (int i = 0; i < `FLSU_ALAT_N; i++) begin
            if (inval && hit_vec[i]) alat_reg[i].valid <= 1'b0;
            if (alloc && slot == i[`FLSU_ALAT_IW-1:0]) begin
               alat_reg[i] <= '{valid: 1'b1, freg: q_reg.f1, paddr: rsp_reg.paddr,
                                size: size_sel};
            end
         end
         if (alloc) rr_reg <= rr_reg + 1'b1;
      end
   end

   // registered effect outputs, each valid and done a one-cycle pulse
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fr_wr0 <= '0;
         fr_wr1 <= '0;
         gr_wr_valid <= 1'b0;
         gr_wr_idx <= '0;
         gr_wr_val <= '0;
         gr_wr_nat <= 1'b0;
         pf_valid <= 1'b0;
         pf_addr <= '0;
         pf_hint <= '0;
         fault_valid <= 1'b0;
         fault_code <= FLT_NONE;
         done <= 1'b0;
      end else begin
         fr_wr0 <= fr0_next;
         fr_wr1 <= fr1_next;
         gr_wr_valid <= fin && upd_on;
         gr_wr_idx <= q_reg.r3;
         gr_wr_val <= base_new;
         gr_wr_nat <= nat_new;
         pf_valid <= fin && upd_on && !nat_new;
         pf_addr <= base_new;
         pf_hint <= q_reg.hint;
         fault_valid <= flt_next != FLT_NONE;
         fault_code <= flt_next;
         done <= fin || (ev && st_next == ST_IDLE) || mem_flt;
      end
   end

   // ahb-lite slave: zero wait states, so hrdata is prepared in the address phase
   wire ahb_sel = hsel && htrans[1] && hready;
   wire [`FLSU_AW-1:0] ahb_a = haddr[`FLSU_AW-1:0];
   wire [31:0] stat_rd = 32'({last_fault_reg, 2'b00, mf_reg});
   wire [31:0] rd_mux = (ahb_a == `FLSU_CTRL_OFS) ? 32'(ctrl_reg) :
                        (ahb_a == `FLSU_STAT_OFS) ? stat_rd :
                        (ahb_a == `FLSU_ALAT_OFS) ? 32'(~free_vec) : 32'h0000_0000;
   wire wr_ctrl = a_valid_reg && a_wr_reg && (a_addr_reg == `FLSU_CTRL_OFS);
   wire wr_stat = a_valid_reg && a_wr_reg && (a_addr_reg == `FLSU_STAT_OFS);
   wire [1:0] mf_clr = wr_stat ? hwdata[1:0] : 2'b00;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // a set in the same cycle as a write-one clear wins
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         a_valid_reg <= 1'b0;
         a_wr_reg <= 1'b0;
         a_addr_reg <= '0;
         hrdata <= '0;
         ctrl_reg <= `FLSU_CTRL_RST;
         mf_reg <= 2'b00;
         last_fault_reg <= FLT_NONE;
      end else begin
         a_valid_reg <= ahb_sel;
         a_wr_reg <= hwrite;
         a_addr_reg <= ahb_a;
         hrdata <= (ahb_sel && !hwrite) ? rd_mux : 32'h0000_0000;
         if (wr_ctrl) ctrl_reg <= hwdata[`FLSU_CTRL_W-1:0];
         mf_reg <= (mf_reg & ~mf_clr) | mf_set;
         if (flt_next != FLT_NONE) last_fault_reg <= flt_next;
      end
   end

   // checks
   sequence s_eval_live;
      ev && q_reg.qp;
   endsequence
   sequence s_fin_access;
      fin && access;
   endsequence

   AST_PAIR_BANK: assert property (s_eval_live ##0 (q_reg.pair && q_reg.f1[0] == q_reg.f2[0])
      |=> fault_valid && fault_code == FLT_ILLEGAL) else $error("pair bank conflict not faulted");
   AST_NAT_FAULT: assert property (s_eval_live ##0 (!illegal && !dis_hit && nat_flt)
      |=> fault_valid && fault_code == FLT_NAT ##1 !fr_wr0.valid) else $error("nat fault missing");
   AST_PRED_FALSE: assert property (ev && !q_reg.qp
      |=> done && !fault_valid ##1 (!fr_wr0.valid && !gr_wr_valid && !mreq.valid))
      else $error("false predicate had an effect");
   AST_DEFER_NOREAD: assert property (s_eval_live ##0 (eval_flt == FLT_NONE && eval_defer)
      |=> !mreq.valid[*2]) else $error("deferred load went to memory");
   AST_HIT_KEEP: assert property (fin && !access |=> !fr_wr0.valid && !fr_wr1.valid)
      else $error("check hit wrote the target");
   AST_TOKEN: assert property (s_fin_access ##0 (defer_reg && spec)
      |=> fr_wr0.valid && fr_wr0.val == flsu_freg_t'(`FLSU_TOKEN)) else $error("token not written");
   AST_ZERO: assert property (s_fin_access ##0 (defer_reg && adv && !spec && is_int)
      |=> fr_wr0.val.exp == `FLSU_EXP_INT && fr_wr0.val.sig == '0) else $error("bad zero result");
   AST_IMM_UPD: assert property (fin && q_reg.upd == UPD_IMM && !q_reg.pair
      |=> gr_wr_valid && gr_wr_val == $past(q_reg.base) + $past(imm_ext))
      else $error("immediate base update wrong");
   AST_REG_NAT: assert property (fin && q_reg.upd == UPD_REG
      |=> gr_wr_nat == ($past(q_reg.base_nat) || $past(q_reg.r2_nat)) && !fault_valid)
      else $error("register update deferred bit wrong");
   AST_PF_GATE: assert property (pf_valid |-> gr_wr_valid && !gr_wr_nat && pf_addr == gr_wr_val)
      else $error("prefetch hint not at clean new base");
   AST_NO_UPD: assert property (fin && !upd_on |=> !gr_wr_valid && !pf_valid)
      else $error("no-update form touched base");
   AST_FILL_SIZE: assert property (mreq.valid && !q_reg.pair && q_reg.form == FORM_FILL
      |-> mreq.size == `FLSU_SZ_FILL) else $error("fill size wrong");
   AST_ALLOC: assert property (alloc |=> (|hit_vec)) else $error("entry not allocated");
   AST_INVAL: assert property (inval && !alloc |=> !(|hit_vec)) else $error("entry survived");
   AST_MF_LOW: assert property (fin && access && tgt_part[0] |=> mf_reg[0])
      else $error("low modified flag not set");
endmodule

/* File: bench/flsu_mem_model.sv */
`timescale 1ns/1ps
module flsu_mem_model import flsu_pkg::*; (
   input wire logic clk,
   input wire logic arst_n,
   input wire flsu_mreq_t mreq,
   input wire logic [3:0] lat,
   input wire logic spec_pg,
   input wire logic dfr,
   output flsu_mrsp_t mrsp
);
   logic [3:0] cnt_reg;
   logic ack_reg;
   wire logic [63:0] va = mreq.vaddr;
   wire logic wait_w = mreq.valid && !ack_reg;
   // hold off lat+1 cycles of a held request, then one ack pulse
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= 4'h0;
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= wait_w && cnt_reg == lat;
         cnt_reg <= (wait_w && cnt_reg != lat) ? cnt_reg + 4'h1 : 4'h0;
      end
   end
   // off the ack cycle the data halves swap, so a stale capture never matches
   assign mrsp = '{ack: ack_reg, data: ack_reg ? {~va, va} : {va, ~va}, paddr: va,
      spec_page: spec_pg, defer: dfr, fault: 1'b0};
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`include "flsu_map.svh"
module testbench import flsu_pkg::*; ();
   localparam logic [63:0] B = 64'h0000_0000_0000_1000;
   localparam logic [63:0] NB = 64'hffff_ffff_ffff_efff;
   localparam logic [63:0] BM = 64'h0000_0000_0000_0ff0;
   logic clk, arst_n, hsel, hwrite, hreadyout, hresp, req_valid, req_ready, spec_pg, dfr, cm;
   logic gr_wr_valid, gr_wr_nat, pf_valid, fault_valid, done;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans, pf_hint;
   logic [2:0] hsize;
   logic [3:0] lat, cf;
   logic [4:0] cs;
   logic [6:0] gr_wr_idx;
   logic [63:0] gr_wr_val, pf_addr, ca;
   logic [64:0] cp;
   logic [65:0] cg;
   flsu_req_t req, r;
   flsu_mreq_t mreq;
   flsu_mrsp_t mrsp;
   flsu_frwr_t fr_wr0, fr_wr1, c0, c1;
   flsu_fault_t fault_code;
   int failures = 0;
   int n_compared = 0;
   flsu_unit i_flsu_unit (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req_valid(req_valid),
      .req(req), .req_ready(req_ready), .mreq(mreq), .mrsp(mrsp), .fr_wr0(fr_wr0),
      .fr_wr1(fr_wr1), .gr_wr_valid(gr_wr_valid), .gr_wr_idx(gr_wr_idx),
      .gr_wr_val(gr_wr_val), .gr_wr_nat(gr_wr_nat), .pf_valid(pf_valid),
      .pf_addr(pf_addr), .pf_hint(pf_hint), .fault_valid(fault_valid),
      .fault_code(fault_code), .done(done));
   flsu_mem_model i_flsu_mem_model (.clk(clk), .arst_n(arst_n), .mreq(mreq), .lat(lat),
      .spec_pg(spec_pg), .dfr(dfr), .mrsp(mrsp));
   task automatic results;
      if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic ck(input string n, input logic [127:0] s, input logic [127:0] e);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("ERROR %s exp %h seen %h", n, e, s);
      end
   endtask
   // one single word transfer; read data taken at the data phase's closing edge
   task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 20'h0_0000, a};
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      {hsel, htrans} <= 3'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      q = hrdata;
   endtask
   function automatic flsu_req_t mk(flsu_ldtype_t t, flsu_upd_t u, logic n);
      mk = '0;
      mk.qp = 1'b1;
      mk.ldtype = t;
      mk.fmt = FMT_D;
      mk.form = FORM_INT;
      mk.upd = u;
      {mk.f1, mk.r3, mk.base, mk.base_nat} = {7'h10, 7'h05, B, n};
      {mk.short_signed_offset, mk.hint} = {9'h1f0, 2'h2};
   endfunction
   // offer one instruction and log every one-cycle effect until done
   task automatic run(input flsu_req_t x);
      int n;
      n = 0;
      {c0, c1, cg, cp, cf, cm} = '0;
      @(posedge clk);
      req <= x;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      while (done !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
         if (mreq.valid === 1'b1) {cm, cs, ca} = {1'b1, mreq.size, mreq.vaddr};
         if (fr_wr0.valid === 1'b1) c0 = fr_wr0;
         if (fr_wr1.valid === 1'b1) c1 = fr_wr1;
         if (gr_wr_valid === 1'b1) cg = {1'b1, gr_wr_nat, gr_wr_val};
         if (pf_valid === 1'b1) cp = {1'b1, pf_addr};
         if (fault_valid === 1'b1) cf = {1'b1, fault_code};
      end
      ck("done", n < 40, 1'b1);
      ck("rdy", {req_ready, hresp}, 2'h2);
   endtask
   task automatic s_imm;
      run(mk(LT_NONE, UPD_IMM, 1'b0));
      ck("size", cs, 5'h08);
      ck("vaddr", ca, B);
      ck("fr", c0, {1'b1, 7'h10, 1'b0, `FLSU_EXP_INT, B});
      ck("gr", cg, {2'h2, BM});
      ck("pf", cp, {1'b1, BM});
      ck("idx", {gr_wr_idx, pf_hint}, {7'h05, 2'h2});
      ahb(1'b0, `FLSU_STAT_OFS, 32'h0000_0000);
      ck("mfl", q[1:0], 2'h1);
      ahb(1'b0, 12'h00c, 32'h0000_0000);
      ck("unmapped", q, 32'h0000_0000);
      r = mk(LT_NONE, UPD_NONE, 1'b0);
      r.form = FORM_FILL;
      run(r);
      ck("fill", {cs, c0.val}, {5'h10, NB[17:0], B});
      r.form = FORM_FP;
      r.fmt = FMT_S;
      run(r);
      ck("single", cs, 5'h04);
      r.fmt = FMT_E;
      run(r);
      ck("ext", cs, 5'h0a);
   endtask
   task automatic s_reg;
      r = mk(LT_NONE, UPD_REG, 1'b0);
      {r.r2_val, r.r2_nat} = {64'h0000_0000_0000_0020, 1'b1};
      run(r);
      ck("gr", cg, {2'h3, 64'h0000_0000_0000_1020});
      ck("pf", cp[64], 1'b0);
      ck("flt", cf, 4'h0);
   endtask
   // slow memory here; table entry made, hit, forced miss, cleared
   task automatic s_alat;
      lat <= 4'h3;
      run(mk(LT_A, UPD_NONE, 1'b0));
      ck("grpf", {cg[65], cp[64]}, 2'h0);
      ahb(1'b0, `FLSU_ALAT_OFS, 32'h0000_0000);
      ck("alloc", |q[3:0], 1'b1);
      run(mk(LT_CNC, UPD_IMM, 1'b0));
      ck("hit", {cm, c0.valid}, 2'h0);
      ck("gr", cg, {2'h2, BM});
      ahb(1'b1, `FLSU_CTRL_OFS, 32'h0000_0001);
      run(mk(LT_CNC, UPD_NONE, 1'b0));
      ck("fmiss", cm, 1'b1);
      ahb(1'b1, `FLSU_CTRL_OFS, 32'h0000_0000);
      run(mk(LT_CCLR, UPD_NONE, 1'b0));
      ck("mem", cm, 1'b0);
      ahb(1'b0, `FLSU_ALAT_OFS, 32'h0000_0000);
      ck("inval", q[3:0], 4'h0);
      spec_pg <= 1'b0;
      run(mk(LT_CNC, UPD_NONE, 1'b0));
      spec_pg <= 1'b1;
      ahb(1'b0, `FLSU_ALAT_OFS, 32'h0000_0000);
      ck("nspec", {cm, q[3:0]}, 5'h10);
      run(mk(LT_A, UPD_NONE, 1'b0));
      dfr <= 1'b1;
      run(mk(LT_A, UPD_NONE, 1'b0));
      dfr <= 1'b0;
      ck("zero", c0.val, `FLSU_INT_ZERO);
      ahb(1'b0, `FLSU_ALAT_OFS, 32'h0000_0000);
      ck("noent", q[3:0], 4'h0);
      lat <= 4'h0;
   endtask
   task automatic s_spec;
      run(mk(LT_S, UPD_NONE, 1'b1));
      ck("mem", cm, 1'b0);
      ck("tok", c0.val, `FLSU_TOKEN);
      ck("flt", cf, 4'h0);
      ahb(1'b1, `FLSU_CTRL_OFS, 32'h0000_0002);
      run(mk(LT_S, UPD_NONE, 1'b0));
      ck("ed", cm, 1'b0);
      run(mk(LT_NONE, UPD_NONE, 1'b1));
      ck("nat", {cm, cf}, {2'h1, FLT_NAT});
      ahb(1'b1, `FLSU_CTRL_OFS, 32'h0000_000a);
      run(mk(LT_NONE, UPD_NONE, 1'b1));
      ck("dis", cf, {1'b1, FLT_DISABLED});
      ahb(1'b1, `FLSU_CTRL_OFS, 32'h0000_0000);
      r = mk(LT_NONE, UPD_IMM, 1'b1);
      r.qp = 1'b0;
      run(r);
      ck("qp", {cm, c0.valid, cg[65], cp[64], cf}, 8'h00);
   endtask
   task automatic s_pair;
      r = mk(LT_NONE, UPD_IMM, 1'b0);
      {r.pair, r.f2} = {1'b1, 7'h11};
      run(r);
      ck("size", cs, 5'h10);
      ck("lo", c0.val, {1'b0, `FLSU_EXP_INT, B});
      ck("hi", c1.val.sig, NB);
      ck("f2", c1.idx, 7'h11);
      ck("gr", cg[63:0], 64'h0000_0000_0000_1010);
      ahb(1'b1, `FLSU_CTRL_OFS, 32'h0000_0004);
      run(r);
      ck("be", c0.val.sig, NB);
      r.f2 = 7'h12;
      run(r);
      ck("par", cf, {1'b1, FLT_ILLEGAL});
   endtask
   // free-running core clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // watchdog well past the few hundred cycles the tests need
   initial begin
      #100000;
      failures++;
      results();
   end
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata, req_valid, req} = '0;
      {hsize, lat, spec_pg, dfr, arst_n} = {3'h2, 4'h1, 1'b1, 1'b0, 1'b0};
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      s_imm();
      s_reg();
      s_alat();
      s_spec();
      s_pair();
      results();
   end
endmodule
